// ### rtl/link_setup.sv
// Purpose: Switch decode, station check, error latch and self-loop test
// Assumes: CPU buffer port is synchronous; switches static at reset
// Notes:   Switches are caught once after reset release; mode change does not recapture them
`timescale 1ns/100ps
module link_setup #(
   parameter int PASS_LEN = link_setup_pkg::PASS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [3:0]  mode_switch,
   input  wire logic        link_role_sel,
   input  wire logic        write_while_running_en,
   input  wire logic        baud_code_bit0,
   input  wire logic        baud_code_bit1,
   input  wire logic        baud_code_bit2,
   input  wire logic        char_length_sel,
   input  wire logic        parity_en,
   input  wire logic        parity_polarity_sel,
   input  wire logic        stop_length_sel,
   input  wire logic        checksum_append_en,
   input  wire logic [3:0]  station_tens_digit,
   input  wire logic [3:0]  station_units_digit,
   input  wire logic        mode_ready_rise,
   input  wire logic        cpu_buffer_write_op,
   input  wire logic        cpu_buffer_read_op,
   input  wire logic [11:0] cpu_addr,
   input  wire logic [15:0] cpu_wdata,
   input  wire logic        cpu_running,
   input  wire logic        illegal_access,
   input  wire logic        cpu_access_abnormal,
   input  wire logic        parity_sum_err,
   input  wire logic        protocol_err,
   input  wire logic        overrun_err,
   input  wire logic        framing_err,
   input  wire logic        rx_area_full_drop,
   input  wire logic [4:0]  msg_station,
   input  wire logic        msg_valid,
   input  wire logic        ext_write_req,
   input  wire logic [10:0] live_status,
   input  wire logic        cpu_check_fail,
   input  wire logic        sio_check_fail,
   output logic [15:0]      cpu_rdata,
   output logic [2:0]       op_mode,
   output logic             multidrop_mode,
   output logic [2:0]       baud_code,
   output logic             char_8bit,
   output logic             parity_on,
   output logic             parity_even,
   output logic             stop_2bit,
   output logic             checksum_on,
   output logic [4:0]       station_num,
   output logic             station_bad,
   output logic             msg_accept,
   output logic             ext_write_allow,
   output logic             run_ind,
   output logic [10:0]      live_ind,
   output logic             cpu_check_go,
   output logic             sio_check_go,
   output logic [3:0]       error_ind,
   output logic             protocol_error_ind,
   output logic             serial_error_ind
);
   localparam logic [3:0]  DIGIT_MAX_T = link_setup_pkg::DIGIT_MAX;
   localparam logic [4:0]  ST_MAX_T    = link_setup_pkg::STATION_MAX;
   localparam logic [31:0] PASS_MAX    = 32'(PASS_LEN - 1);

   logic                          rst_meta;
   logic                          rst_n;
   logic                          sampled;
   logic                          init_pulse;
   logic [2:0]                    baud_raw;
   logic [15:0]                   bidir_word;
   logic [3:0]                    mode_sw;
   logic [31:0]                   pass_cnt;
   link_setup_pkg::test_state_t   tstate;
   logic                          cpu_fail_seen;
   logic                          sio_fail_seen;

   err_if eif ();

   err_latch u_latch (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .bus   (eif.latch)
   );

   // Two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign baud_raw   = {baud_code_bit2, baud_code_bit1, baud_code_bit0};
   // Sample once after release; mode change re-initialises indicators and the bidirectional setting word
   assign init_pulse = ce && (!sampled || mode_ready_rise);

   // Switch capture: later switch moves are ignored until reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampled        <= 1'b0;
         mode_sw        <= 4'h0;
         multidrop_mode <= 1'b0;
         baud_code      <= 3'h0;
         char_8bit      <= 1'b0;
         parity_on      <= 1'b0;
         parity_even    <= 1'b0;
         stop_2bit      <= 1'b0;
         checksum_on    <= 1'b0;
         station_num    <= 5'h00;
         station_bad    <= 1'b0;
         ext_write_allow <= 1'b0;
      end else if (ce && !sampled) begin
         sampled        <= 1'b1;
         mode_sw        <= mode_switch;
         multidrop_mode <= !link_role_sel;
         baud_code      <= baud_raw;
         char_8bit      <= char_length_sel;
         parity_on      <= parity_en;
         parity_even    <= parity_polarity_sel;
         stop_2bit      <= stop_length_sel;
         checksum_on    <= checksum_append_en;
         station_num    <= 5'(station_tens_digit * 4'hA
                              + station_units_digit);
         station_bad    <= station_tens_digit > DIGIT_MAX_T
                           || station_units_digit > DIGIT_MAX_T
                           || 8'(station_tens_digit * 4'hA
                              + station_units_digit) > 8'(ST_MAX_T);
         ext_write_allow <= write_while_running_en;
      end
   end

   // Bidirectional setting word written by the CPU
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bidir_word <= 16'h0000;
      end else if (ce) begin
         if (init_pulse) begin
            bidir_word <= 16'h0000;
         end else if (cpu_buffer_write_op
                      && cpu_addr == link_setup_pkg::ADDR_BIDIR_SET) begin
            bidir_word <= cpu_wdata;
         end
      end
   end

   // Mode decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_mode <= 3'(link_setup_pkg::OPM_UNUSABLE);
      end else if (ce) begin
         if (mode_sw == link_setup_pkg::MODE_NOPROT) begin
            op_mode <= (bidir_word == 16'h0001)
               ? 3'(link_setup_pkg::OPM_BIDIR)
               : 3'(link_setup_pkg::OPM_NOPROT);
         end else if (mode_sw >= link_setup_pkg::MODE_PROT1
                      && mode_sw <= link_setup_pkg::MODE_PROT4) begin
            op_mode <= 3'(link_setup_pkg::OPM_PROTOCOL);
         end else if (mode_sw == link_setup_pkg::MODE_TEST) begin
            op_mode <= 3'(link_setup_pkg::OPM_TEST);
         end else begin
            op_mode <= 3'(link_setup_pkg::OPM_UNUSABLE);
         end
      end
   end

   // Run indicator and live status; live bits never latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ind  <= 1'b0;
         live_ind <= 11'h000;
      end else if (ce) begin
         run_ind  <= sampled && baud_code != link_setup_pkg::BAUD_BAD
                     && op_mode != 3'(link_setup_pkg::OPM_UNUSABLE);
         live_ind <= live_status;
      end
   end

   // Station filter; multidrop answers own number, refuse if disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         msg_accept <= 1'b0;
      end else if (ce) begin
         msg_accept <= msg_valid && run_ind
            && (!multidrop_mode || msg_station == station_num)
            && !(ext_write_req && cpu_running && !ext_write_allow
                 && op_mode == 3'(link_setup_pkg::OPM_PROTOCOL));
      end
   end

   // Self test sequencer: CPU check, serial check, wait out the pass
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tstate       <= link_setup_pkg::ST_IDLE;
         pass_cnt     <= 32'h0;
         cpu_check_go <= 1'b0;
         sio_check_go <= 1'b0;
      end else if (ce) begin
         cpu_check_go <= 1'b0;
         sio_check_go <= 1'b0;
         unique case (tstate)
            link_setup_pkg::ST_IDLE: begin
               if (sampled && op_mode == 3'(link_setup_pkg::OPM_TEST)
                   && run_ind) begin
                  tstate       <= link_setup_pkg::ST_CPU_CHK;
                  cpu_check_go <= 1'b1;
                  pass_cnt     <= 32'h0;
               end
            end
            link_setup_pkg::ST_CPU_CHK: begin
               tstate       <= link_setup_pkg::ST_SIO_CHK;
               sio_check_go <= 1'b1;
               pass_cnt     <= pass_cnt + 32'h1;
            end
            link_setup_pkg::ST_SIO_CHK: begin
               tstate   <= link_setup_pkg::ST_WAIT;
               pass_cnt <= pass_cnt + 32'h1;
            end
            link_setup_pkg::ST_WAIT: begin
               if (pass_cnt >= PASS_MAX) begin
                  tstate       <= link_setup_pkg::ST_CPU_CHK;
                  cpu_check_go <= 1'b1;
                  pass_cnt     <= 32'h0;
               end else begin
                  pass_cnt <= pass_cnt + 32'h1;
               end
            end
         endcase
      end
   end

   // Failures only raise flags; the sequence never stops
   assign cpu_fail_seen = cpu_check_fail && tstate != link_setup_pkg::ST_IDLE;
   assign sio_fail_seen = sio_check_fail && tstate != link_setup_pkg::ST_IDLE;

   always_comb begin
      eif.init  = init_pulse;
      eif.set_ev = '0;
      eif.set_ev[link_setup_pkg::ERR_CN] = illegal_access
         || cpu_access_abnormal || cpu_fail_seen;
      eif.set_ev[link_setup_pkg::ERR_PS]  = parity_sum_err;
      eif.set_ev[link_setup_pkg::ERR_PRO] = protocol_err;
      eif.set_ev[link_setup_pkg::ERR_SIO] = overrun_err || framing_err
         || rx_area_full_drop || sio_fail_seen;
      eif.clr_ev = '0;
      if (cpu_buffer_write_op
          && cpu_addr == link_setup_pkg::ADDR_ERR_CLEAR) begin
         eif.clr_ev = cpu_wdata[link_setup_pkg::ERR_COUNT-1:0];
      end
   end

   // Error outputs and status read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_ind          <= 4'h0;
         protocol_error_ind <= 1'b0;
         serial_error_ind   <= 1'b0;
         cpu_rdata          <= 16'h0000;
      end else if (ce) begin
         error_ind          <= eif.state;
         protocol_error_ind <= eif.state[link_setup_pkg::ERR_PRO];
         serial_error_ind   <= eif.state[link_setup_pkg::ERR_SIO];
         if (cpu_buffer_read_op
             && cpu_addr == link_setup_pkg::ADDR_ERR_STATUS) begin
            cpu_rdata <= {12'h000, eif.state};
         end else begin
            cpu_rdata <= 16'h0000;
         end
      end
   end

   chk_status_rd: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cpu_buffer_read_op && cpu_addr == link_setup_pkg::ADDR_ERR_STATUS
      ##1 ce |-> cpu_rdata == {12'h000, $past(eif.state)})
      else $error("status word does not mirror indicators");
   chk_clr_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !init_pulse && eif.clr_ev[0] && !eif.set_ev[0]
      |=> !ce || !eif.state[0])
      else $error("requested clear did not take effect");
   chk_sio_set: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !init_pulse && (overrun_err || framing_err) |=> !ce || eif.state[3])
      else $error("serial error not latched");
   chk_cn_set: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !init_pulse && illegal_access |=> !ce || eif.state[0])
      else $error("cpu communication error not latched");
   chk_bad_baud: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sampled && baud_code == link_setup_pkg::BAUD_BAD |=> !run_ind)
      else $error("run lit with unusable baud code");
   chk_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n)
      sampled && $past(sampled) |-> $stable(baud_code) && $stable(mode_sw))
      else $error("switch setting changed during operation");
   chk_test_seq: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tstate == link_setup_pkg::ST_CPU_CHK
      |=> !ce || tstate == link_setup_pkg::ST_SIO_CHK)
      else $error("serial check did not follow cpu check");
   chk_init_clear: assert property (@(posedge clk) disable iff (!rst_n)
      init_pulse |=> !ce || eif.state == '0)
      else $error("indicators not initialised");
   cov_clear: cover property (@(posedge clk) eif.clr_ev != '0);
   cov_test_loop: cover property (@(posedge clk)
      tstate == link_setup_pkg::ST_WAIT ##1 cpu_check_go);
   cov_multidrop: cover property (@(posedge clk) msg_accept && multidrop_mode);
endmodule

// ### rtl/link_setup_pkg.sv
// Purpose: Shared constants for the link setup and error latch block
// Assumes: 16-bit buffer words, 20 MHz clock
// Notes:   Switch fields are sampled once after reset; mode change does not resample them
package link_setup_pkg;
   localparam logic [11:0] ADDR_ERR_STATUS = 12'h101;
   localparam logic [11:0] ADDR_ERR_CLEAR  = 12'h102;
   localparam logic [11:0] ADDR_BIDIR_SET  = 12'h10F;
   localparam int          ERR_COUNT       = 4;
   localparam int          ERR_CN          = 0;
   localparam int          ERR_PS          = 1;
   localparam int          ERR_PRO         = 2;
   localparam int          ERR_SIO         = 3;
   localparam logic [3:0]  MODE_NOPROT     = 4'h4;
   localparam logic [3:0]  MODE_PROT1      = 4'h5;
   localparam logic [3:0]  MODE_PROT4      = 4'h8;
   localparam logic [3:0]  MODE_TEST       = 4'hF;
   localparam logic [2:0]  BAUD_BAD        = 3'h7;
   localparam logic [4:0]  STATION_MAX     = 5'h1F;
   localparam logic [3:0]  DIGIT_MAX       = 4'h9;
   localparam int          PASS_TIME_MS    = 1000;
   localparam int          CLK_KHZ         = 20000;
   localparam int          PASS_CYCLES     = PASS_TIME_MS * CLK_KHZ;
   typedef enum logic [2:0] {
      OPM_UNUSABLE, OPM_NOPROT, OPM_BIDIR, OPM_PROTOCOL, OPM_TEST
   } op_mode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_CPU_CHK, ST_SIO_CHK, ST_WAIT}
      test_state_t;
endpackage

// ### rtl/err_if.sv
// Purpose: Carries error events and clear requests to the latch
// Assumes: Single clock domain
// Notes:   Events are one-cycle pulses
`timescale 1ns/100ps
interface err_if;
   logic [link_setup_pkg::ERR_COUNT-1:0] set_ev;
   logic [link_setup_pkg::ERR_COUNT-1:0] clr_ev;
   logic                                 init;
   logic [link_setup_pkg::ERR_COUNT-1:0] state;
   modport src (output set_ev, output clr_ev, output init, input state);
   modport latch (input set_ev, input clr_ev, input init, output state);
endinterface

// ### rtl/err_latch.sv
// Purpose: Sticky error indicators with per-bit clear
// Assumes: Reset synchronised by the parent
// Notes:   A set in the clearing cycle wins
`timescale 1ns/100ps
module err_latch (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   err_if.latch      bus
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.state <= '0;
      end else if (ce) begin
         if (bus.init) begin
            bus.state <= '0;
         end else begin
            bus.state <= bus.set_ev | (bus.state & ~bus.clr_ev);
         end
      end
   end

   // Clear and init act one edge later, so look at them one cycle back
   chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
      ce && $past(ce) && !$past(bus.init) && $past(bus.state[0])
      && !$past(bus.clr_ev[0]) |-> bus.state[0])
      else $error("latched indicator dropped without clear");
endmodule

// ### verification/host_link_model.sv
// Purpose: Far-side host issuing addressed messages and write requests
// Assumes: One message per go pulse from the bench
// Notes:   Station field is scrambled while no message is valid
`timescale 1ns/100ps
module host_link_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [4:0] station,
   input  wire logic       write_in,
   output logic            msg_valid,
   output logic [4:0]      msg_station,
   output logic            ext_write_req
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         msg_valid     <= 1'b0;
         msg_station   <= 5'h00;
         ext_write_req <= 1'b0;
      end else begin
         msg_valid     <= go;
         ext_write_req <= write_in;
         // Stale field inverted so a match never comes for free
         msg_station   <= go ? station : ~msg_station;
      end
   end
endmodule

// ### verification/tb_link_setup.sv
// Purpose: Self-checking bench for the link setup block
// Assumes: Pass length shortened to 16 cycles
// Notes:   Switches are set before each reset and checked after it
`timescale 1ns/100ps
module tb_link_setup;
   localparam int PLEN = 16;
   logic        clk, arst_n, rd, wr, go, run, mrr, ext_wr, cfail, sfail, ce;
   logic [3:0]  mode, tens, units, error_ind;
   logic [9:0]  sw;
   logic [11:0] addr;
   logic [15:0] wdata, cpu_rdata;
   logic [6:0]  ev;
   logic [10:0] live, live_ind;
   logic [4:0]  st_cmd, msg_station, station_num;
   logic [2:0]  op_mode, baud_code;
   logic        msg_valid, ext_write_req, multidrop_mode, char_8bit;
   logic        parity_on, parity_even, stop_2bit, checksum_on, station_bad;
   logic        msg_accept, ext_write_allow, run_ind, cpu_check_go;
   logic        sio_check_go, protocol_error_ind, serial_error_ind;
   int          n_fail, checks_done, cnt, nc, ns;
   int          bitpos [7] = '{0, 0, 1, 2, 3, 3, 3};

   link_setup #(.PASS_LEN(PLEN)) u_link_setup (.clk(clk), .arst_n(arst_n),
      .ce(ce), .mode_switch(mode), .link_role_sel(sw[0]),
      .write_while_running_en(sw[1]), .baud_code_bit0(sw[2]),
      .baud_code_bit1(sw[3]), .baud_code_bit2(sw[4]),
      .char_length_sel(sw[5]), .parity_en(sw[6]),
      .parity_polarity_sel(sw[7]), .stop_length_sel(sw[8]),
      .checksum_append_en(sw[9]), .station_tens_digit(tens),
      .station_units_digit(units), .mode_ready_rise(mrr),
      .cpu_buffer_write_op(wr), .cpu_buffer_read_op(rd), .cpu_addr(addr),
      .cpu_wdata(wdata), .cpu_running(run), .illegal_access(ev[0]),
      .cpu_access_abnormal(ev[1]), .parity_sum_err(ev[2]),
      .protocol_err(ev[3]), .overrun_err(ev[4]), .framing_err(ev[5]),
      .rx_area_full_drop(ev[6]), .msg_station(msg_station),
      .msg_valid(msg_valid), .ext_write_req(ext_write_req),
      .live_status(live), .cpu_check_fail(cfail), .sio_check_fail(sfail),
      .cpu_rdata(cpu_rdata), .op_mode(op_mode),
      .multidrop_mode(multidrop_mode), .baud_code(baud_code),
      .char_8bit(char_8bit), .parity_on(parity_on),
      .parity_even(parity_even), .stop_2bit(stop_2bit),
      .checksum_on(checksum_on), .station_num(station_num),
      .station_bad(station_bad), .msg_accept(msg_accept),
      .ext_write_allow(ext_write_allow), .run_ind(run_ind),
      .live_ind(live_ind), .cpu_check_go(cpu_check_go),
      .sio_check_go(sio_check_go), .error_ind(error_ind),
      .protocol_error_ind(protocol_error_ind),
      .serial_error_ind(serial_error_ind));

   host_link_model u_host_link_model (.clk(clk), .rst_n(arst_n), .go(go),
      .station(st_cmd), .write_in(ext_wr), .msg_valid(msg_valid),
      .msg_station(msg_station), .ext_write_req(ext_write_req));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results;
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic reset_with(input logic [3:0] m, input logic [9:0] s,
                             input logic [3:0] t, input logic [3:0] u);
      @(posedge clk);
      mode   <= m;
      sw     <= s;
      tens   <= t;
      units  <= u;
      arst_n <= 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      tick(6);
   endtask

   // Strobe stands one cycle; read data is valid on return
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [15:0] d);
      @(posedge clk);
      wr    <= w;
      rd    <= !w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask

   task automatic pulse_ev(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= '0;
      tick(2);
   endtask

   task automatic cfg_chk(input logic [8:0] e, input logic [5:0] s,
                          input logic r, input logic wa);
      chk({7'h00, multidrop_mode, baud_code, char_8bit,
           parity_on, parity_even, stop_2bit, checksum_on},
           {7'h00, e});
      chk({10'h000, station_num, station_bad}, {10'h000, s});
      chk({14'h0000, run_ind, ext_write_allow},
          {14'h0000, r, wa});
   endtask

   // Write flag travels with the message through the host model
   task automatic send_msg(input logic [4:0] s, input logic w,
                           input logic exp);
      @(posedge clk);
      go     <= 1'b1;
      st_cmd <= s;
      ext_wr <= w;
      @(posedge clk);
      go <= 1'b0;
      tick(1);
      chk({15'h0000, msg_accept}, {15'h0000, exp});
   endtask

   initial begin
      {arst_n, rd, wr, go, mrr, cfail, sfail} = '0;
      {run, ext_wr, ce} = 3'h7;
      {mode, sw, tens, units, addr, wdata, ev, live, st_cmd} = '0;
      n_fail = 0;
      checks_done = 0;
      for (int m = 0; m < 16; m++) begin
         reset_with(m[3:0], 10'h16D, 4'h1, 4'h7);
         cnt = (m == 4) ? 1 : (m >= 5 && m <= 8) ? 3 : (m == 15) ? 4 : 0;
         chk({13'h0000, op_mode}, cnt[15:0]);
      end
      reset_with(4'h5, 10'h16D, 4'h1, 4'h7);
      cfg_chk(9'h07A, {5'd17, 1'b0}, 1'b1, 1'b0);
      // Switch moves after reset must not reach the outputs
      @(posedge clk);
      sw    <= 10'h292;
      units <= 4'h9;
      tick(3);
      cfg_chk(9'h07A, {5'd17, 1'b0}, 1'b1, 1'b0);
      // Point-to-point: any station, writes refused while running
      send_msg(5'd5, 1'b0, 1'b1);
      send_msg(5'd17, 1'b1, 1'b0);
      for (int i = 0; i < 7; i++) begin
         pulse_ev(i);
         cnt = 1 << bitpos[i];
         chk({12'h000, error_ind}, cnt[15:0]);
         tick(5);
         chk({14'h0000, protocol_error_ind, serial_error_ind},
             {14'h0000, cnt[2], cnt[3]});
         bus(1'b0, link_setup_pkg::ADDR_ERR_STATUS, 16'h0000);
         chk(cpu_rdata, cnt[15:0]);
         bus(1'b1, link_setup_pkg::ADDR_ERR_CLEAR, cnt[15:0]);
         tick(2);
         chk({12'h000, error_ind}, 16'h0000);
      end
      pulse_ev(3);
      pulse_ev(5);
      bus(1'b1, link_setup_pkg::ADDR_ERR_CLEAR, 16'h0004);
      tick(2);
      bus(1'b0, link_setup_pkg::ADDR_ERR_STATUS, 16'h0000);
      chk(cpu_rdata, 16'h0008);
      bus(1'b0, link_setup_pkg::ADDR_ERR_CLEAR, 16'h0000);
      chk(cpu_rdata, 16'h0000);
      bus(1'b0, 12'h200, 16'h0000);
      chk(cpu_rdata, 16'h0000);
      @(posedge clk);
      live <= 11'h5A5;
      tick(2);
      chk({5'h00, live_ind}, 16'h05A5);
      @(posedge clk);
      live <= 11'h000;
      tick(2);
      chk({5'h00, live_ind}, 16'h0000);
      // Enable low: an event must not reach the latch
      @(posedge clk);
      ce <= 1'b0;
      pulse_ev(2);
      @(posedge clk);
      ce <= 1'b1;
      tick(2);
      chk({12'h000, error_ind}, 16'h0008);
      reset_with(4'h5, 10'h292, 4'h3, 4'h1);
      cfg_chk(9'h185, {5'd31, 1'b0}, 1'b1, 1'b1);
      // Multidrop: own station only, writes allowed while running
      send_msg(5'd31, 1'b1, 1'b1);
      send_msg(5'd5, 1'b0, 1'b0);
      // Unusable baud code and an out-of-range station together
      reset_with(4'h5, 10'h01C, 4'h3, 4'h2);
      chk({14'h0000, run_ind, station_bad}, 16'h0001);
      reset_with(4'h4, 10'h16D, 4'h1, 4'h7);
      bus(1'b1, link_setup_pkg::ADDR_BIDIR_SET, 16'h0001);
      tick(2);
      chk({13'h0000, op_mode}, 16'h0002);
      pulse_ev(5);
      @(posedge clk);
      mrr <= 1'b1;
      @(posedge clk);
      mrr <= 1'b0;
      tick(2);
      chk({9'h000, op_mode, error_ind}, 16'h0010);
      @(posedge clk);
      cfail <= 1'b1;
      sfail <= 1'b1;
      reset_with(4'hF, 10'h16D, 4'h1, 4'h7);
      cnt = 0;
      while (cpu_check_go !== 1'b1 && cnt < 40) begin
         tick(1);
         cnt++;
      end
      if (cpu_check_go !== 1'b1) begin
         n_fail++;
      end else begin
         tick(1);
         chk({15'h0000, sio_check_go}, 16'h0001);
         nc = 0;
         ns = 0;
         // Window of four whole passes starts just after a pass start
         for (int k = 0; k < 4 * PLEN; k++) begin
            tick(1);
            nc += int'(cpu_check_go === 1'b1);
            ns += int'(sio_check_go === 1'b1);
         end
         chk(nc[15:0], 16'h0004);
         chk(ns[15:0], 16'h0004);
         chk({12'h000, error_ind}, 16'h0009);
      end
      results();
   end
endmodule
